// file: src/rmc_pkg.sv
// Constants and types of the radio modem control register bank
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package rmc_pkg;
   //-------------------------------------------------------------------
   // Register map
   //-------------------------------------------------------------------
   localparam logic [15:0] ACK_CORR_ADDR = 16'hDF04;
   localparam logic [15:0] TEST_MODE_ADDR = 16'hDF05;
   localparam logic [15:0] CCA_LEVEL_ADDR = 16'hDF06;
   localparam logic [15:0] SIG_STRENGTH_ADDR = 16'hDF07;
   localparam logic [15:0] AUX_CTRL_ADDR = 16'hDF10;
   localparam logic [7:0] ACK_CORR_RESET = 8'h30;
   localparam logic [7:0] TEST_MODE_RESET = 8'h00;
   localparam logic [7:0] CCA_LEVEL_RESET = 8'hE0;
   localparam logic [7:0] SIG_STRENGTH_RESET = 8'h00;
   localparam logic [7:0] AUX_CTRL_RESET = 8'h16;
   localparam logic [7:0] TEST_MODE_MASK = 8'h3F;
   localparam logic [4:0] CORR_LEGACY_VALUE = 5'h14;
   //-------------------------------------------------------------------
   // Field positions
   //-------------------------------------------------------------------
   localparam int SLOTTED_ACK_BIT = 7;
   localparam int STRICT_FILT_BIT = 5;
   localparam int CORR_THRESHOLD_LSB = 0;
   localparam int DC_AVG_MODE_BIT = 5;
   localparam int PHASE_REV_BIT = 4;
   localparam int TX_TEST_LSB = 2;
   localparam int RX_TEST_LSB = 0;
   localparam int AUTO_ACK_BIT = 0;
   localparam int CCA_SELECT_LSB = 1;
   localparam int CCA_HYSTERESIS_LSB = 3;
   //-------------------------------------------------------------------
   // Timing
   //-------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 10000;
   localparam int SYMBOL_PERIOD_PS = 16000000;
   localparam int SYMBOL_CYCLES = SYMBOL_PERIOD_PS / CLK_PERIOD_PS;
   localparam logic [4:0] ACK_MIN_SYMBOLS = 5'd12;
   localparam logic [4:0] ACK_MAX_SYMBOLS = 5'd30;
   localparam logic [4:0] SLOT_SYMBOLS = 5'd20;
   localparam int RSSI_AVG_SYMBOLS = 8;
   //-------------------------------------------------------------------
   // Types
   //-------------------------------------------------------------------
   typedef enum logic [1:0] {
      TX_QUEUE, TX_SERIAL, TX_LOOP, TX_RANDOM
   } rmc_tx_test_e;
   typedef enum logic [1:0] {
      RX_QUEUE, RX_PINS, RX_LOOP, RX_RESERVED
   } rmc_rx_test_e;
   typedef struct packed {
      logic slotted_ack;
      logic strict_correlation_filtering;
      logic [4:0] correlation_threshold;
      logic dc_average_mode;
      logic phase_reverse;
      rmc_tx_test_e tx_test;
      rmc_rx_test_e rx_test;
      logic tx_endless;
      logic rx_endless;
      logic automatic_acknowledge;
      logic [1:0] clear_channel_select;
   } rmc_cfg_s;
endpackage

// file: src/rmc_sym_avg.sv
// Moving average of signal strength over a window of symbol samples
`timescale 1ns/1ps
`default_nettype none
module rmc_sym_avg #(
   parameter int DEPTH_LOG2 = 3
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic sample_en_in,
   input wire logic signed [7:0] sample_in,
   output logic signed [7:0] avg_out
);
   localparam int DEPTH = 1 << DEPTH_LOG2;
   logic signed [7:0] win_q [DEPTH];
   logic signed [8+DEPTH_LOG2-1:0] sum_q;
   logic signed [8+DEPTH_LOG2-1:0] sum_d;

   // Running sum: add newest, drop oldest, so no adder tree is needed
   always_comb begin
      sum_d = sum_q + (8+DEPTH_LOG2)'(sample_in)
         - (8+DEPTH_LOG2)'(win_q[DEPTH-1]);
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            win_q[i] <= 8'sh00;
         end
         sum_q <= '0;
      end else if (sample_en_in) begin
         win_q[0] <= sample_in;
         for (int i = 1; i < DEPTH; i++) begin
            win_q[i] <= win_q[i-1];
         end
         sum_q <= sum_d;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         avg_out <= 8'sh00;
      end else begin
         avg_out <= sum_q[8+DEPTH_LOG2-1:DEPTH_LOG2];
      end
   end
endmodule // rmc_sym_avg
`default_nettype wire

// file: src/rmc_top.sv
// Radio modem control register bank with acknowledgment timing
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rmc_top (
   input wire logic CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic [15:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [7:0] RDATA_OUT,
   input wire logic SFD_RX_IN,
   input wire logic FRAME_END_IN,
   input wire logic ADDR_MATCH_IN,
   input wire logic ACK_REQ_IN,
   input wire logic CRC_OK_IN,
   input wire logic PREAMBLE_MATCH_IN,
   input wire logic [4:0] CORR_IN,
   input wire logic signed [7:0] RSSI_IN,
   output var rmc_pkg::rmc_cfg_s CFG_OUT,
   output logic ACK_START_OUT,
   output logic SFD_SEARCH_EN_OUT,
   output logic DC_FREEZE_OUT,
   output logic CCA_OUT
);
   //-------------------------------------------------------------------
   // Registers
   //-------------------------------------------------------------------
   logic [7:0] ack_corr_q;
   logic [7:0] test_mode_q;
   logic [7:0] cca_level_q;
   logic [7:0] aux_ctrl_q;
   logic [7:0] rdata_d;
   logic signed [7:0] rssi_avg;
   logic slotted;
   logic [4:0] corr_level;
   logic [1:0] cca_select;
   logic [2:0] cca_margin;

   assign slotted = ack_corr_q[rmc_pkg::SLOTTED_ACK_BIT];
   assign corr_level = ack_corr_q[rmc_pkg::CORR_THRESHOLD_LSB +: 5];
   assign cca_select = aux_ctrl_q[rmc_pkg::CCA_SELECT_LSB +: 2];
   assign cca_margin = aux_ctrl_q[rmc_pkg::CCA_HYSTERESIS_LSB +: 3];

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ack_corr_q <= rmc_pkg::ACK_CORR_RESET;
         test_mode_q <= rmc_pkg::TEST_MODE_RESET;
         cca_level_q <= rmc_pkg::CCA_LEVEL_RESET;
         aux_ctrl_q <= rmc_pkg::AUX_CTRL_RESET;
      end else if (WR_IN) begin
         case (ADDR_IN)
            rmc_pkg::ACK_CORR_ADDR: begin
               ack_corr_q <= WDATA_IN;
            end
            rmc_pkg::TEST_MODE_ADDR: begin
               test_mode_q <= WDATA_IN & rmc_pkg::TEST_MODE_MASK;
            end
            rmc_pkg::CCA_LEVEL_ADDR: begin
               cca_level_q <= WDATA_IN;
            end
            rmc_pkg::AUX_CTRL_ADDR: begin
               aux_ctrl_q <= WDATA_IN & 8'h3F;
            end
            default: begin
            end
         endcase
      end
   end

   // Read data stands for one cycle only, zero otherwise
   always_comb begin
      rdata_d = 8'h00;
      if (RD_IN) begin
         case (ADDR_IN)
            rmc_pkg::ACK_CORR_ADDR: rdata_d = ack_corr_q;
            rmc_pkg::TEST_MODE_ADDR: begin
               rdata_d = test_mode_q & rmc_pkg::TEST_MODE_MASK;
            end
            rmc_pkg::CCA_LEVEL_ADDR: rdata_d = cca_level_q;
            rmc_pkg::SIG_STRENGTH_ADDR: rdata_d = rssi_avg;
            rmc_pkg::AUX_CTRL_ADDR: rdata_d = aux_ctrl_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         RDATA_OUT <= 8'h00;
      end else begin
         RDATA_OUT <= rdata_d;
      end
   end

   //-------------------------------------------------------------------
   // Configuration to the modem datapath
   //-------------------------------------------------------------------
   // One cycle behind the registers; keeps the port flop-driven
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         CFG_OUT <= '0;
      end else begin
         CFG_OUT.slotted_ack <= slotted;
         CFG_OUT.strict_correlation_filtering <=
            ack_corr_q[rmc_pkg::STRICT_FILT_BIT];
         CFG_OUT.correlation_threshold <= corr_level;
         CFG_OUT.dc_average_mode <= test_mode_q[rmc_pkg::DC_AVG_MODE_BIT];
         CFG_OUT.phase_reverse <= test_mode_q[rmc_pkg::PHASE_REV_BIT];
         CFG_OUT.tx_test <= rmc_pkg::rmc_tx_test_e'(
            test_mode_q[rmc_pkg::TX_TEST_LSB +: 2]);
         CFG_OUT.rx_test <= rmc_pkg::rmc_rx_test_e'(
            test_mode_q[rmc_pkg::RX_TEST_LSB +: 2]);
         // Every non-queue transmit mode runs without end
         CFG_OUT.tx_endless <=
            test_mode_q[rmc_pkg::TX_TEST_LSB +: 2] != 2'b00;
         // Reserved receive code behaves as normal queue use
         CFG_OUT.rx_endless <=
            test_mode_q[rmc_pkg::RX_TEST_LSB +: 2] == 2'b01 ||
            test_mode_q[rmc_pkg::RX_TEST_LSB +: 2] == 2'b10;
         CFG_OUT.automatic_acknowledge <= aux_ctrl_q[rmc_pkg::AUTO_ACK_BIT];
         CFG_OUT.clear_channel_select <= cca_select;
      end
   end

   //-------------------------------------------------------------------
   // Symbol tick
   //-------------------------------------------------------------------
   typedef enum logic {ACK_IDLE, ACK_WAIT} rmc_ack_state_e;
   rmc_ack_state_e ack_state_q;
   logic [10:0] presc_q;
   logic sym_tick;
   logic ack_accept;
   assign sym_tick = presc_q == 11'(rmc_pkg::SYMBOL_CYCLES - 1);
   // Frames during a pending wait are ignored and must not realign ticks
   assign ack_accept = FRAME_END_IN && aux_ctrl_q[rmc_pkg::AUTO_ACK_BIT]
      && ADDR_MATCH_IN && ACK_REQ_IN && CRC_OK_IN
      && ack_state_q == ACK_IDLE;

   // Realigned on an accepted frame so the fixed delay is exact
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         presc_q <= 11'h000;
      end else if (ack_accept || sym_tick) begin
         presc_q <= 11'h000;
      end else begin
         presc_q <= presc_q + 11'h001;
      end
   end

   // Symbols since the last received frame delimiter, modulo a slot
   logic [4:0] slot_phase_q;
   logic [4:0] slot_phase_d;
   always_comb begin
      slot_phase_d = slot_phase_q + 5'h01;
      if (slot_phase_q == rmc_pkg::SLOT_SYMBOLS - 5'h01) begin
         slot_phase_d = 5'h00;
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         slot_phase_q <= 5'h00;
      end else if (SFD_RX_IN) begin
         slot_phase_q <= 5'h00;
      end else if (sym_tick) begin
         slot_phase_q <= slot_phase_d;
      end
   end

   //-------------------------------------------------------------------
   // Acknowledgment timing
   //-------------------------------------------------------------------
   logic [4:0] ack_syms_q;
   logic [4:0] ack_syms_d;
   logic ack_fire;

   assign ack_syms_d = ack_syms_q + 5'h01;

   always_comb begin
      ack_fire = 1'b0;
      if (ack_state_q == ACK_WAIT && sym_tick) begin
         if (!slotted) begin
            ack_fire = ack_syms_d == rmc_pkg::ACK_MIN_SYMBOLS;
         end else begin
            // Slot boundary at or past the minimum; cap bounds the wait
            ack_fire = (ack_syms_d >= rmc_pkg::ACK_MIN_SYMBOLS &&
               slot_phase_d == 5'h00) ||
               ack_syms_d == rmc_pkg::ACK_MAX_SYMBOLS;
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ack_state_q <= ACK_IDLE;
         ack_syms_q <= 5'h00;
      end else begin
         case (ack_state_q)
            ACK_IDLE: begin
               if (ack_accept) begin
                  ack_state_q <= ACK_WAIT;
                  ack_syms_q <= 5'h00;
               end
            end
            ACK_WAIT: begin
               if (ack_fire) begin
                  ack_state_q <= ACK_IDLE;
               end else if (sym_tick) begin
                  ack_syms_q <= ack_syms_d;
               end
            end
            default: begin
               ack_state_q <= ACK_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ACK_START_OUT <= 1'b0;
      end else begin
         ACK_START_OUT <= ack_fire;
      end
   end

   //-------------------------------------------------------------------
   // Demodulator gating
   //-------------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         SFD_SEARCH_EN_OUT <= 1'b0;
      end else begin
         SFD_SEARCH_EN_OUT <= CORR_IN >= corr_level;
      end
   end

   // Set wins over the end-of-frame release
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         DC_FREEZE_OUT <= 1'b0;
      end else if (test_mode_q[rmc_pkg::DC_AVG_MODE_BIT]) begin
         DC_FREEZE_OUT <= 1'b0;
      end else if (PREAMBLE_MATCH_IN) begin
         DC_FREEZE_OUT <= 1'b1;
      end else if (FRAME_END_IN) begin
         DC_FREEZE_OUT <= 1'b0;
      end
   end

   //-------------------------------------------------------------------
   // Signal strength and clear channel
   //-------------------------------------------------------------------
   rmc_sym_avg #(
      .DEPTH_LOG2($clog2(rmc_pkg::RSSI_AVG_SYMBOLS))
   ) i_rmc_sym_avg (
      .clk_in(CLK_IN),
      .reset_n_in(RESET_N_IN),
      .sample_en_in(sym_tick),
      .sample_in(RSSI_IN),
      .avg_out(rssi_avg)
   );

   logic signed [8:0] cca_limit;
   always_comb begin
      cca_limit = 9'(signed'(cca_level_q));
      if (cca_select == 2'b01) begin
         cca_limit = cca_limit - 9'(signed'({1'b0, cca_margin}));
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         CCA_OUT <= 1'b0;
      end else begin
         CCA_OUT <= 9'(rssi_avg) < cca_limit;
      end
   end

   //-------------------------------------------------------------------
   // Checks
   //-------------------------------------------------------------------
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RESET_N_IN);

   // Counter is 1 after accept; pulse lands one cycle after the last tick
   localparam int ACK_FIXED_CYCLES =
      rmc_pkg::SYMBOL_CYCLES * int'(rmc_pkg::ACK_MIN_SYMBOLS) + 1;
   logic [15:0] ast_wait_q;
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ast_wait_q <= 16'h0000;
      end else if (ack_accept && ack_state_q == ACK_IDLE) begin
         ast_wait_q <= 16'h0001;
      end else if (ack_state_q == ACK_WAIT) begin
         ast_wait_q <= ast_wait_q + 16'h0001;
      end
   end

   AST_ACK_FIXED: assert property (
      ACK_START_OUT && !slotted |->
         ast_wait_q == 16'(ACK_FIXED_CYCLES))
      else $error("Unslotted acknowledgment not at 12 symbols");
   AST_ACK_SLOT: assert property (
      ack_fire && slotted |-> ack_syms_d >= rmc_pkg::ACK_MIN_SYMBOLS &&
         (slot_phase_d == 5'h00 || ack_syms_d == rmc_pkg::ACK_MAX_SYMBOLS))
      else $error("Slotted acknowledgment off slot boundary");
   AST_ACK_QUALIFY: assert property (
      $rose(ack_state_q == ACK_WAIT) |-> $past(ADDR_MATCH_IN) &&
         $past(ACK_REQ_IN) && $past(CRC_OK_IN) &&
         $past(aux_ctrl_q[rmc_pkg::AUTO_ACK_BIT]))
      else $error("Acknowledgment armed for unqualified frame");
   AST_SFD_GATE: assert property (
      SFD_SEARCH_EN_OUT |-> $past(CORR_IN) >= $past(corr_level))
      else $error("Frame-start search below correlation threshold");
   AST_DC_LOCK: assert property (
      !test_mode_q[rmc_pkg::DC_AVG_MODE_BIT] && PREAMBLE_MATCH_IN
         ##1 !test_mode_q[rmc_pkg::DC_AVG_MODE_BIT] |-> DC_FREEZE_OUT)
      else $error("DC level not locked after preamble");
   AST_DC_CONT: assert property (
      test_mode_q[rmc_pkg::DC_AVG_MODE_BIT] |=> !DC_FREEZE_OUT)
      else $error("DC level frozen in continuous mode");
   AST_TEST_WRITE: assert property (
      WR_IN && ADDR_IN == rmc_pkg::TEST_MODE_ADDR |-> ##2
         CFG_OUT.tx_test == $past(WDATA_IN[3:2], 2) &&
         CFG_OUT.phase_reverse == $past(WDATA_IN[4], 2))
      else $error("Test mode write not reflected");
   AST_RSVD_ZERO: assert property (
      RD_IN && ADDR_IN == rmc_pkg::TEST_MODE_ADDR |=>
         RDATA_OUT[7:6] == 2'b00)
      else $error("Reserved test-mode bits read nonzero");
   AST_RSSI_READ: assert property (
      RD_IN && ADDR_IN == rmc_pkg::SIG_STRENGTH_ADDR |=>
         RDATA_OUT == $past(rssi_avg))
      else $error("Signal strength read mismatch");
   AST_CCA: assert property (
      cca_select != 2'b01 |=>
         CCA_OUT == ($past(rssi_avg) < signed'($past(cca_level_q))))
      else $error("Clear channel disagrees with threshold");
   AST_CLEAR_CHANNEL_HYSTERESIS: assert property (
      cca_select == 2'b01 |=> CCA_OUT == (10'($past(rssi_avg)) +
         10'(signed'({1'b0, $past(cca_margin)})) <
         10'(signed'($past(cca_level_q)))))
      else $error("Clear channel ignores hysteresis");
   AST_RX_ENDLESS: assert property (
      CFG_OUT.rx_endless == (CFG_OUT.rx_test == rmc_pkg::RX_PINS ||
         CFG_OUT.rx_test == rmc_pkg::RX_LOOP))
      else $error("Receive endless flag disagrees with test mode");
endmodule // rmc_top
`default_nettype wire

// file: tb/test_rmc_top.sv
// Self-checking bench for the radio modem control register bank
`timescale 1ns/1ps
`default_nettype none
module test_rmc_top;
   logic clk, rst_n, wr, rd, sfd, fend, amatch, areq, crc_ok, pre;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [4:0] corr;
   logic signed [7:0] rssi;
   rmc_pkg::rmc_cfg_s cfg;
   logic ack, sfd_en, dc_frz, cca;
   int mismatches = 0;
   int num_checks = 0;
   int n;

   rmc_top i_rmc_top (.CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr),
      .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
      .SFD_RX_IN(sfd), .FRAME_END_IN(fend), .ADDR_MATCH_IN(amatch),
      .ACK_REQ_IN(areq), .CRC_OK_IN(crc_ok), .PREAMBLE_MATCH_IN(pre),
      .CORR_IN(corr), .RSSI_IN(rssi), .CFG_OUT(cfg), .ACK_START_OUT(ack),
      .SFD_SEARCH_EN_OUT(sfd_en), .DC_FREEZE_OUT(dc_frz), .CCA_OUT(cca));

   //-------------------------------------------------------------------
   // Shared tasks
   //-------------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string msg);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg,
                  seen, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e,
                         input string msg);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata, e, msg);
   endtask

   // Qualifiers in order: address match, acknowledge request, checksum
   task automatic frame(input logic [2:0] q);
      @(posedge clk);
      fend <= 1'b1;
      {amatch, areq, crc_ok} <= q;
      @(posedge clk);
      fend <= 1'b0;
      #1;
   endtask

   // Counts cycles from the frame-end cycle to the acknowledgment pulse
   task automatic wait_ack(input int limit);
      n = 1;
      while (ack !== 1'b1 && n < limit) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   //-------------------------------------------------------------------
   // Scenarios
   //-------------------------------------------------------------------
   task automatic test_reset;
      rd_chk(16'hDF04, 8'h30, "ack corr reset");
      rd_chk(16'hDF05, 8'h00, "test mode reset");
      rd_chk(16'hDF06, 8'hE0, "cca level reset");
      rd_chk(16'hDF07, 8'h00, "strength reset");
      rd_chk(16'hDF10, 8'h16, "aux reset");
      rd_chk(16'hDF20, 8'h00, "unmapped read");
      check({3'h0, cfg.correlation_threshold}, 8'h10, "thr cfg");
      check({7'h0, cfg.strict_correlation_filtering}, 8'h01, "strict");
      $display("test reset done");
   endtask

   task automatic test_regs;
      logic [1:0] m;
      wr_reg(16'hDF05, 8'hFF);
      rd_chk(16'hDF05, 8'h3F, "reserved bits");
      wr_reg(16'hDF07, 8'h55);
      rd_chk(16'hDF07, 8'h00, "read only");
      wr_reg(16'hDF20, 8'hAA);
      rd_chk(16'hDF20, 8'h00, "unmapped write");
      wr_reg(16'hDF04, 8'hC5);
      rd_chk(16'hDF04, 8'hC5, "ack corr rw");
      tick(2);
      check({7'h0, cfg.slotted_ack}, 8'h01, "slotted cfg");
      check({7'h0, cfg.strict_correlation_filtering}, 8'h00, "legacy");
      check({3'h0, cfg.correlation_threshold}, 8'h05, "thr cfg");
      for (int i = 0; i < 4; i++) begin
         m = i[1:0];
         wr_reg(16'hDF05, {3'b000, m[0], m, m});
         tick(2);
         check({6'h0, cfg.tx_test}, {6'h0, m}, "tx test");
         check({7'h0, cfg.tx_endless}, {7'h0, m != 2'b00}, "tx end");
         check({6'h0, cfg.rx_test}, {6'h0, m}, "rx test");
         check({7'h0, cfg.rx_endless}, {7'h0, m == 2'b01 || m == 2'b10},
               "rx endless");
         check({7'h0, cfg.phase_reverse}, {7'h0, m[0]}, "phase");
      end
      $display("test registers done");
   endtask

   task automatic test_sfd_search;
      wr_reg(16'hDF04, 8'h30);
      @(posedge clk);
      corr <= 5'h0F;
      tick(3);
      check({7'h0, sfd_en}, 8'h00, "below threshold");
      @(posedge clk);
      corr <= 5'h10;
      tick(3);
      check({7'h0, sfd_en}, 8'h01, "at threshold");
      $display("test frame-start search done");
   endtask

   task automatic test_dc;
      wr_reg(16'hDF05, 8'h00);
      @(posedge clk);
      pre <= 1'b1;
      @(posedge clk);
      pre <= 1'b0;
      tick(2);
      check({7'h0, dc_frz}, 8'h01, "freeze on preamble");
      frame(3'b011);
      tick(2);
      check({7'h0, dc_frz}, 8'h00, "release at frame end");
      @(posedge clk);
      pre <= 1'b1;
      @(posedge clk);
      pre <= 1'b0;
      wr_reg(16'hDF05, 8'h20);
      tick(3);
      check({7'h0, dc_frz}, 8'h00, "continuous mode");
      check({7'h0, cfg.dc_average_mode}, 8'h01, "dc mode cfg");
      $display("test dc average done");
   endtask

   task automatic test_ack;
      wr_reg(16'hDF10, 8'h17);
      tick(3);
      frame(3'b111);
      wait_ack(20000);
      check({7'h0, n == 19201}, 8'h01, "unslotted delay");
      tick(2);
      check({7'h0, ack}, 8'h00, "one-cycle pulse");
      // Each missing qualifier alone must block the acknowledgment
      frame(3'b011);
      frame(3'b101);
      frame(3'b110);
      wait_ack(19300);
      check({7'h0, ack}, 8'h00, "refused frame");
      wr_reg(16'hDF04, 8'hB0);
      tick(3);
      @(posedge clk);
      sfd <= 1'b1;
      @(posedge clk);
      sfd <= 1'b0;
      frame(3'b111);
      wait_ack(52000);
      // Delimiter gap lands on the 20-symbol slot boundary
      check({7'h0, n >= 30400 && n <= 33601}, 8'h01, "slotted");
      $display("test acknowledgment done");
   endtask

   task automatic test_cca;
      wr_reg(16'hDF06, 8'hE0);
      @(posedge clk);
      rssi <= 8'shD8;
      tick(16000);
      rd_chk(16'hDF07, 8'hD8, "averaged strength");
      check({7'h0, cca}, 8'h01, "below threshold");
      wr_reg(16'hDF06, 8'hD0);
      tick(3);
      check({7'h0, cca}, 8'h00, "above threshold");
      wr_reg(16'hDF06, 8'hDA);
      tick(3);
      check({7'h0, cca}, 8'h01, "plain threshold");
      wr_reg(16'hDF10, 8'h13);
      tick(4);
      check({7'h0, cca}, 8'h00, "hysteresis");
      check({6'h0, cfg.clear_channel_select}, 8'h01, "cca select");
      check({7'h0, cfg.automatic_acknowledge}, 8'h01, "auto ack");
      $display("test clear channel done");
   endtask

   //-------------------------------------------------------------------
   // Run control
   //-------------------------------------------------------------------
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Tests need about 87k cycles
   initial begin
      #1000000;
      mismatches++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_sim();
   end

   initial begin
      rst_n = 1'b0;
      {wr, rd, sfd, fend, pre} = 5'b00000;
      {amatch, areq, crc_ok} = 3'b111;
      addr = 16'h0000;
      wdata = 8'h00;
      corr = 5'h00;
      rssi = 8'sh00;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      test_reset();
      test_regs();
      test_sfd_search();
      test_dc();
      test_ack();
      test_cca();
      end_sim();
   end
endmodule // test_rmc_top
`default_nettype wire
